// ===== udc_regs.svh
// Purpose: Register indexes, field positions and reset values of the UART DMA control block.
// Assumes: Byte address of a register is four times its index.
// Notes:   Definitions only.
`ifndef UDC_REGS_SVH
`define UDC_REGS_SVH

`define UDC_IDX_TX_STAT  16'hFFE1
`define UDC_IDX_RX_DEF   16'hFFE4
`define UDC_IDX_RX_STAT  16'hFFE5
`define UDC_IDX_TX_CTRL  16'hFFF0
`define UDC_IDX_IRQ_STAT 16'hFFF1
`define UDC_IDX_IRQ_CLR  16'hFFF2
`define UDC_IDX_IRQ_EN   16'hFFF3

`define UDC_TX_PARTIAL_PACKET_FLAG_BIT  0
`define UDC_TX_INE_BIT   6
`define UDC_TX_RUN_BIT   7
`define UDC_RXD_DIR_BIT  3
`define UDC_RXD_TGL_BIT  4
`define UDC_RXD_RUN_BIT  7
`define UDC_RXS_OVF_BIT  0
`define UDC_RXS_TOF_BIT  1
`define UDC_IRQ_TX_BIT   0
`define UDC_IRQ_RX_BIT   1

`define UDC_RX_DEF_RST   8'h08
`define UDC_RX_STAT_RST  8'h00
`define UDC_IRQ_RST      2'h0

`endif

// ===== udc_pkg.sv
// Purpose: Types shared by the UART DMA control block.
// Assumes: Field order matches the register bit order, msb first.
// Notes:   Constants live in udc_regs.svh.
package udc_pkg;

  typedef struct packed {
    logic       run;
    logic       irq_en;
    logic       cont;
    logic       toggle;
    logic       dir;
    logic [2:0] desc_sel;
  } udc_rx_def_s;

  typedef struct packed {
    logic       tmo_en;
    logic [4:0] tmo_val;
    logic       tmo_flag;
    logic       ovf_flag;
  } udc_rx_stat_s;

  typedef enum logic [2:0] {
    UDC_TMO_IDLE  = 3'b001,
    UDC_TMO_ARMED = 3'b010,
    UDC_TMO_COUNT = 3'b100
  } udc_tmo_state_e;

endpackage

// ===== udc_uart_dma_ctrl.sv
// Purpose: Control and status of the UART transmit and receive DMA channels.
// Assumes: APB slave, one wait-free access phase, all inputs synchronous to mclk.
// Notes:   Event inputs are one-cycle pulses from the datapath and buffer manager.
//
// Overview of operation
// R1 - Partial packet sets flag; software clears it.
// R2 - Write one clears flag; zero keeps it.
// R3 - Interrupt disabled: partial packet keeps channel running.
// R4 - Transmit status upper bits read zero.
// R5 - Descriptor select picks endpoint descriptor block.
// R6 - Direction reads one; zero write updates toggle.
// R7 - Toggle zero selects X, one Y.
// R8 - Software always writes continuous mode one.
// R9 - Buffer manager sets toggle; DMA follows it.
// R10 - Time-out ends transfer, updates block, interrupts.
// R11 - UART error ends transfer without DMA interrupt.
// R12 - UART error interrupt comes from UART.
// R13 - Interrupt disabled: flags do not stop channel.
// R14 - Interrupt enabled: run falling edge interrupts.
// R15 - Software starts run; DMA clears at end.
// R16 - Halt writes back count, clears NAK.
// R17 - Time-out counter reloads per byte, frame decrements.
// R18 - Overflow set by DMA, write one clears.
// R19 - Read-only writes ignored; reset restores defaults.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`include "udc_regs.svh"

module udc_uart_dma_ctrl #(
  parameter int BCNT_W = 8,
  parameter int ADDR_W = 18
) (
  input  wire logic                 mclk,
  input  wire logic                 rst,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [ADDR_W-1:0]    paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 tx_partial_pkt,
  input  wire logic                 rx_byte_xfer,
  input  wire logic                 usb_sof,
  input  wire logic                 uart_rx_err,
  input  wire logic                 rx_overflow,
  input  wire logic                 ubm_toggle_wr,
  input  wire logic                 ubm_toggle_val,
  output logic                      tx_run,
  output udc_pkg::udc_rx_def_s      rx_def,
  output logic                      edb_wb,
  output logic      [BCNT_W-1:0]    edb_byte_count,
  output logic                      irq
);
  import udc_pkg::*;

  // The register indexes need at least 18 address bits once shifted to byte addresses.
  if (ADDR_W < 18 || ADDR_W > 32 || BCNT_W < 1 || BCNT_W > 16)
  begin : g_bad_param
    $error("udc_uart_dma_ctrl: unsupported parameter values");
  end

  logic                 tx_partial_packet_flag;
  logic                 tx_ine;
  udc_rx_stat_s         rx_stat;
  udc_tmo_state_e       tmo_state;
  logic [4:0]           tmo_cnt;
  logic [BCNT_W-1:0]    rx_bcnt;
  logic [1:0]           irq_stat;
  logic [1:0]           irq_en;
  logic                 setup;
  logic                 wr_acc;
  logic                 w_txs;
  logic                 w_rxd;
  logic                 w_rxs;
  logic                 w_txc;
  logic                 w_clr;
  logic                 w_ien;
  logic                 rx_expire;
  logic                 rx_term_err;
  logic                 rx_halt;
  logic                 next_rx_run;
  logic                 next_tx_run;
  logic                 tx_evt;
  logic                 rx_evt;
  logic [31:0]          rd_data;
  logic                 rd_hit;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
    return a == ADDR_W'({idx, 2'b00});
  endfunction

  assign setup  = psel & ~penable;
  assign wr_acc = psel & penable & pready & pwrite;
  assign w_txs  = wr_acc & hit(paddr, `UDC_IDX_TX_STAT);
  assign w_rxd  = wr_acc & hit(paddr, `UDC_IDX_RX_DEF);
  assign w_rxs  = wr_acc & hit(paddr, `UDC_IDX_RX_STAT);
  assign w_txc  = wr_acc & hit(paddr, `UDC_IDX_TX_CTRL);
  assign w_clr  = wr_acc & hit(paddr, `UDC_IDX_IRQ_CLR);
  assign w_ien  = wr_acc & hit(paddr, `UDC_IDX_IRQ_EN);

  // R17 counter expiry
  assign rx_expire = (tmo_state == UDC_TMO_COUNT) & usb_sof & ~rx_byte_xfer
                     & (tmo_cnt <= 5'h01);

  // R11 error ends the transfer unless software writes the receive definition in the same cycle
  assign rx_term_err = rx_def.run & uart_rx_err;

  // R13 flags halt only with interrupt enabled
  assign rx_halt = rx_term_err
                   | (rx_def.run & rx_def.irq_en & (rx_expire | rx_overflow));

  // A software write in the same cycle wins, so a restart is never lost.
  assign next_rx_run = w_rxd ? pwdata[`UDC_RXD_RUN_BIT] : (rx_def.run & ~rx_halt);

  // R3 partial packet stops only with interrupt enabled
  assign next_tx_run = w_txc ? pwdata[`UDC_TX_RUN_BIT]
                             : (tx_run & ~(tx_partial_pkt & tx_ine));

  assign tx_evt = tx_run & ~next_tx_run & tx_ine;

  // R14 falling run raises event, R12 except error
  assign rx_evt = rx_def.run & ~next_rx_run & rx_def.irq_en & ~rx_term_err;

  // Transmit status flag.
  always_ff @(posedge mclk)
  begin
    if (rst)
      tx_partial_packet_flag <= 1'b0;
    // R1 set wins over clear
    else if (tx_partial_pkt)
      tx_partial_packet_flag <= 1'b1;
    // R2 write one clears
    else if (w_txs & pwdata[`UDC_TX_PARTIAL_PACKET_FLAG_BIT])
      tx_partial_packet_flag <= 1'b0;
  end

  // Transmit run and interrupt enable.
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      tx_run <= 1'b0;
      tx_ine <= 1'b0;
    end
    else
    begin
      tx_run <= next_tx_run;
      if (w_txc)
        tx_ine <= pwdata[`UDC_TX_INE_BIT];
    end
  end

  // Receive channel definition.
  always_ff @(posedge mclk)
  begin
    // R19 reset restores defaults
    if (rst)
      rx_def <= udc_rx_def_s'(`UDC_RX_DEF_RST);
    else
    begin
      // R15 software start, hardware stop
      rx_def.run <= next_rx_run;
      if (w_rxd)
      begin
        // R5 descriptor select
        rx_def.desc_sel <= pwdata[2:0];
        rx_def.cont     <= pwdata[5];
        rx_def.irq_en   <= pwdata[6];
        // R6 toggle only with direction written zero
        if (!pwdata[`UDC_RXD_DIR_BIT])
          // R7 toggle selects X or Y
          rx_def.toggle <= pwdata[`UDC_RXD_TGL_BIT];
      end
      // R9 buffer manager drives toggle
      else if (ubm_toggle_wr & rx_def.cont)
        rx_def.toggle <= ubm_toggle_val;
    end
  end

  // Receive status flags and time-out setup.
  always_ff @(posedge mclk)
  begin
    if (rst)
      rx_stat <= udc_rx_stat_s'(`UDC_RX_STAT_RST);
    else
    begin
      if (w_rxs)
      begin
        rx_stat.tmo_en  <= pwdata[7];
        rx_stat.tmo_val <= pwdata[6:2];
      end
      // R18 overflow set wins over clear
      if (rx_def.run & rx_overflow)
        rx_stat.ovf_flag <= 1'b1;
      else if (w_rxs & pwdata[`UDC_RXS_OVF_BIT])
        rx_stat.ovf_flag <= 1'b0;
      // R17 expiry sets the time-out flag
      if (rx_def.run & rx_expire)
        rx_stat.tmo_flag <= 1'b1;
      else if (w_rxs & pwdata[`UDC_RXS_TOF_BIT])
        rx_stat.tmo_flag <= 1'b0;
    end
  end

  // Counting only starts after the first byte, so an idle line never times out.
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      tmo_state <= UDC_TMO_IDLE;
      tmo_cnt   <= 5'h00;
    end
    else
    begin
      case (tmo_state)
        UDC_TMO_IDLE:
        begin
          if (rx_def.run & rx_stat.tmo_en)
            tmo_state <= UDC_TMO_ARMED;
        end
        UDC_TMO_ARMED:
        begin
          if (!rx_def.run | !rx_stat.tmo_en)
            tmo_state <= UDC_TMO_IDLE;
          else if (rx_byte_xfer)
          begin
            tmo_state <= UDC_TMO_COUNT;
            tmo_cnt   <= rx_stat.tmo_val;
          end
        end
        UDC_TMO_COUNT:
        begin
          if (!rx_def.run | !rx_stat.tmo_en)
            tmo_state <= UDC_TMO_IDLE;
          // R17 reload on byte, decrement on frame
          else if (rx_byte_xfer)
            tmo_cnt <= rx_stat.tmo_val;
          else if (rx_expire)
          begin
            tmo_state <= UDC_TMO_ARMED;
            tmo_cnt   <= 5'h00;
          end
          else if (usb_sof)
            tmo_cnt <= tmo_cnt - 5'h01;
        end
        default:
        begin
          tmo_state <= UDC_TMO_IDLE;
          tmo_cnt   <= 5'h00;
        end
      endcase
    end
  end

  // Byte count of the running transfer and its write-back.
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rx_bcnt        <= '0;
      edb_wb         <= 1'b0;
      edb_byte_count <= '0;
    end
    else
    begin
      // R16 halt writes back count and clears NAK
      edb_wb <= rx_def.run & ~next_rx_run;
      if (rx_def.run & ~next_rx_run)
        edb_byte_count <= rx_bcnt + BCNT_W'(rx_byte_xfer);
      if (!rx_def.run)
        rx_bcnt <= '0;
      else if (rx_byte_xfer)
        rx_bcnt <= rx_bcnt + BCNT_W'(1);
    end
  end

  // Interrupt status, enable and output.
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      irq_stat <= `UDC_IRQ_RST;
      irq_en   <= `UDC_IRQ_RST;
      irq      <= 1'b0;
    end
    else
    begin
      if (w_ien)
        irq_en <= pwdata[1:0];
      // R10 time-out completion interrupt, set wins over clear
      irq_stat[`UDC_IRQ_TX_BIT] <= tx_evt
        | (irq_stat[`UDC_IRQ_TX_BIT] & ~(w_clr & pwdata[`UDC_IRQ_TX_BIT]));
      irq_stat[`UDC_IRQ_RX_BIT] <= rx_evt
        | (irq_stat[`UDC_IRQ_RX_BIT] & ~(w_clr & pwdata[`UDC_IRQ_RX_BIT]));
      irq <= |(irq_stat & irq_en);
    end
  end

  // Read mux; unused high bits read zero.
  always_comb
  begin
    rd_data = 32'h0000_0000;
    rd_hit  = 1'b1;
    // R4 upper transmit status bits zero
    if (hit(paddr, `UDC_IDX_TX_STAT))
      rd_data = {31'h0000_0000, tx_partial_packet_flag};
    // R6 direction bit reads one
    else if (hit(paddr, `UDC_IDX_RX_DEF))
      rd_data = {24'h00_0000, rx_def.run, rx_def.irq_en, rx_def.cont,
                 rx_def.toggle, 1'b1, rx_def.desc_sel};
    else if (hit(paddr, `UDC_IDX_RX_STAT))
      rd_data = {24'h00_0000, rx_stat};
    else if (hit(paddr, `UDC_IDX_TX_CTRL))
      rd_data = {24'h00_0000, tx_run, tx_ine, 6'h00};
    else if (hit(paddr, `UDC_IDX_IRQ_STAT))
      rd_data = {30'h0000_0000, irq_stat};
    else if (hit(paddr, `UDC_IDX_IRQ_EN))
      rd_data = {30'h0000_0000, irq_en};
    else if (!hit(paddr, `UDC_IDX_IRQ_CLR))
      rd_hit = 1'b0;
  end

  // Data is captured in the setup cycle, so the access phase never waits.
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup & ~rd_hit;
      if (setup)
        prdata <= pwrite ? 32'h0000_0000 : rd_data;
    end
  end

  property p_partial_packet_flag_set;
    @(posedge mclk) disable iff (rst) tx_partial_pkt |=> tx_partial_packet_flag;
  endproperty
  a_partial_packet_flag_set: assert property (p_partial_packet_flag_set) else $error("partial flag not set"); // R1

  property p_partial_packet_flag_w0;
    @(posedge mclk) disable iff (rst)
      tx_partial_packet_flag && w_txs && !pwdata[0] |=> tx_partial_packet_flag;
  endproperty
  a_partial_packet_flag_w0: assert property (p_partial_packet_flag_w0) else $error("zero write cleared flag"); // R2

  property p_tx_keep;
    @(posedge mclk) disable iff (rst) tx_run && !tx_ine && !w_txc |=> tx_run;
  endproperty
  a_tx_keep: assert property (p_tx_keep) else $error("transmit run dropped"); // R3

  property p_txs_zero;
    @(posedge mclk) disable iff (rst)
      setup && !pwrite && hit(paddr, `UDC_IDX_TX_STAT) |=> prdata[31:1] == 31'h0;
  endproperty
  a_txs_zero: assert property (p_txs_zero) else $error("status upper bits set"); // R4

  property p_desc;
    @(posedge mclk) disable iff (rst) w_rxd |=> rx_def.desc_sel == $past(pwdata[2:0]);
  endproperty
  a_desc: assert property (p_desc) else $error("descriptor select not stored"); // R5

  property p_dir_one;
    @(posedge mclk) disable iff (rst)
      setup && !pwrite && hit(paddr, `UDC_IDX_RX_DEF) |=> prdata[3];
  endproperty
  a_dir_one: assert property (p_dir_one) else $error("direction read zero"); // R6

  property p_toggle;
    @(posedge mclk) disable iff (rst)
      ubm_toggle_wr && rx_def.cont && !w_rxd |=> rx_def.toggle == $past(ubm_toggle_val);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle not followed"); // R9

  property p_err_stop;
    @(posedge mclk) disable iff (rst)
      rx_def.run && uart_rx_err && !w_rxd && !irq_stat[1] |=> !rx_def.run && !irq_stat[1];
  endproperty
  a_err_stop: assert property (p_err_stop) else $error("error stop wrong"); // R11

  property p_noine;
    @(posedge mclk) disable iff (rst)
      rx_def.run && !rx_def.irq_en && !uart_rx_err && !w_rxd |=> rx_def.run;
  endproperty
  a_noine: assert property (p_noine) else $error("run dropped with irq off"); // R13

  property p_ovf_irq;
    @(posedge mclk) disable iff (rst)
      rx_def.run && rx_def.irq_en && rx_overflow && !uart_rx_err && !w_rxd
      |=> !rx_def.run && irq_stat[1];
  endproperty
  a_ovf_irq: assert property (p_ovf_irq) else $error("no interrupt on stop"); // R14

  property p_wb;
    @(posedge mclk) disable iff (rst) $fell(rx_def.run) |-> edb_wb;
  endproperty
  a_wb: assert property (p_wb) else $error("no write-back on halt"); // R16

  property p_tmo;
    @(posedge mclk) disable iff (rst) rx_def.run && rx_expire |=> rx_stat.tmo_flag;
  endproperty
  a_tmo: assert property (p_tmo) else $error("time-out flag not set"); // R17

  property p_rst;
    @(posedge mclk) disable iff (rst)
      $past(rst) |-> !tx_partial_packet_flag && rx_def == udc_rx_def_s'(`UDC_RX_DEF_RST) && !irq;
  endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong"); // R19

endmodule // udc_uart_dma_ctrl

// ===== udc_far_model.sv
// Purpose: Far-side model of the UART receiver and the USB buffer manager.
// Assumes: The bench raises one request vector for one cycle, synchronous to mclk.
// Notes:   Request bits 5 to 0 each become a one-cycle pulse at the next edge; bit 6 gives the toggle value.
`timescale 1ns/1ps

module udc_far_model (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic [6:0] ev_req,
  output logic            tx_partial_pkt,
  output logic            rx_byte_xfer,
  output logic            usb_sof,
  output logic            uart_rx_err,
  output logic            rx_overflow,
  output logic            ubm_toggle_wr,
  output logic            ubm_toggle_val
);
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      {ubm_toggle_wr, rx_overflow, uart_rx_err, usb_sof, rx_byte_xfer, tx_partial_pkt} <= 6'h00;
      ubm_toggle_val <= 1'b0;
    end
    else
    begin
      {ubm_toggle_wr, rx_overflow, uart_rx_err, usb_sof, rx_byte_xfer, tx_partial_pkt} <=
        ev_req[5:0];
      // Outside a write the value line flips, so a stale level is never trusted.
      ubm_toggle_val <= ev_req[5] ? ev_req[6] : ~ubm_toggle_val;
    end
  end
endmodule // udc_far_model

// ===== udc_uart_dma_ctrl_test.sv
// Purpose: Self-checking bench of the UART DMA control block.
// Assumes: APB reads and writes; events come from the far-side model.
// Notes:   Expected values follow the register layout, not the design.
`timescale 1ns/1ps
`include "udc_regs.svh"

module udc_uart_dma_ctrl_test;
  import udc_pkg::*;
  localparam logic [15:0] TXS = `UDC_IDX_TX_STAT;
  localparam logic [15:0] RXD = `UDC_IDX_RX_DEF;
  localparam logic [15:0] RXS = `UDC_IDX_RX_STAT;
  localparam logic [15:0] TXC = `UDC_IDX_TX_CTRL;
  localparam logic [15:0] IST = `UDC_IDX_IRQ_STAT;
  localparam logic [15:0] ICL = `UDC_IDX_IRQ_CLR;
  localparam logic [15:0] IEN = `UDC_IDX_IRQ_EN;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [17:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [6:0]  ev_req = '0;
  logic [31:0] prdata;
  logic        pready, pslverr, tx_run, edb_wb, irq;
  logic        tpp, rbx, sof, uerr, rovf, tgw, tgv;
  udc_rx_def_s rx_def;
  logic [7:0]  edb_byte_count;
  logic [31:0] rdv;
  logic        errv;
  int          n_mismatch = 0;
  int          check_count = 0;
  int          n_wb = 0;

  udc_uart_dma_ctrl uut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_partial_pkt(tpp), .rx_byte_xfer(rbx), .usb_sof(sof),
    .uart_rx_err(uerr), .rx_overflow(rovf), .ubm_toggle_wr(tgw), .ubm_toggle_val(tgv),
    .tx_run(tx_run), .rx_def(rx_def), .edb_wb(edb_wb), .edb_byte_count(edb_byte_count),
    .irq(irq));

  udc_far_model far (.mclk(mclk), .rst(rst), .ev_req(ev_req), .tx_partial_pkt(tpp),
    .rx_byte_xfer(rbx), .usb_sof(sof), .uart_rx_err(uerr), .rx_overflow(rovf),
    .ubm_toggle_wr(tgw), .ubm_toggle_val(tgv));

  initial forever #50 mclk = ~mclk;

  always @(posedge mclk)
    if (edb_wb === 1'b1) n_wb <= n_wb + 1;

  task end_sim;
    if (n_mismatch == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [15:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask

  task rd(input logic [15:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rdv, {24'h000000, exp});
  endtask

  task nap;
    repeat (3) @(posedge mclk);
  endtask

  task ev(input logic [6:0] v);
    @(posedge mclk);
    ev_req <= v;
    @(posedge mclk);
    ev_req <= 7'h00;
    nap();
  endtask

  task t_reset;
    chk(rx_def, 32'h08);
    rd(TXS, 8'h00);
    rd(RXD, 8'h08);
    rd(RXS, 8'h00);
    apb(1'b0, 16'h0000, 8'h00);
    chk({31'h0, errv}, 32'h1);
  endtask

  task t_tx;
    wr(TXC, 8'h80);
    ev(7'h01);
    chk(tx_run, 1'b1);
    rd(TXS, 8'h01);
    wr(TXS, 8'hFE);
    rd(TXS, 8'h01);
    wr(TXS, 8'h01);
    rd(TXS, 8'h00);
  endtask

  task t_tx_irq;
    wr(IEN, 8'h00);
    wr(TXC, 8'hC0);
    ev(7'h01);
    chk({tx_run, irq}, 2'b00);
    rd(IST, 8'h01);
    wr(IEN, 8'h03);
    nap();
    chk(irq, 1'b1);
    wr(ICL, 8'h01);
    nap();
    chk(irq, 1'b0);
    wr(TXS, 8'h01);
  endtask

  task t_rxdef;
    wr(RXD, 8'h35);
    rd(RXD, 8'h3D);
    chk({rx_def.desc_sel, rx_def.toggle}, 4'hB);
    wr(RXD, 8'h2D);
    rd(RXD, 8'h3D);
    ev(7'h20);
    chk(rx_def.toggle, 1'b0);
    ev(7'h60);
    chk(rx_def.toggle, 1'b1);
  endtask

  task t_ovf;
    int n0;
    n0 = n_wb;
    wr(RXD, 8'hE2);
    repeat (3) ev(7'h02);
    ev(7'h10);
    chk({rx_def.run, irq}, 2'b01);
    chk(n_wb, n0 + 1);
    chk(edb_byte_count, 8'h03);
    rd(RXS, 8'h01);
    wr(RXS, 8'h00);
    rd(RXS, 8'h01);
    wr(RXS, 8'h01);
    rd(RXS, 8'h00);
    wr(ICL, 8'h02);
    wr(RXD, 8'hA0);
    ev(7'h10);
    chk({rx_def.run, irq}, 2'b10);
    wr(RXS, 8'h01);
  endtask

  task t_err;
    int n0;
    wr(RXD, 8'hE0);
    n0 = n_wb;
    ev(7'h08);
    chk({rx_def.run, irq}, 2'b00);
    chk(n_wb, n0 + 1);
    rd(IST, 8'h00);
  endtask

  task t_tmo;
    wr(RXS, 8'h88);
    wr(RXD, 8'hE0);
    ev(7'h02);
    ev(7'h04);
    ev(7'h02);
    ev(7'h04);
    chk(rx_def.run, 1'b1);
    ev(7'h04);
    chk({rx_def.run, irq}, 2'b01);
    rd(RXS, 8'h8A);
    rd(IST, 8'h02);
  endtask

  initial
  begin
    #(5000 * 100);
    n_mismatch++;
    end_sim();
  end

  initial
  begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    t_reset();
    t_tx();
    t_tx_irq();
    t_rxdef();
    t_ovf();
    t_err();
    t_tmo();
    end_sim();
  end
endmodule // udc_uart_dma_ctrl_test
